// [hw/pfs_sequencer.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`include "pfs_defines.svh"
module pfs_sequencer
    import pfs_pkg::*;
#(
    parameter int PHASES = `PFS_PHASES
) (
    input  logic                   clk_i,
    input  logic                   reset_i,
    input  logic                   ce_i,
    input  pfs_bus_t               bus_i,
    output logic [`PFS_DATA_W-1:0] rdata_o,
    input  logic                   link_clk_i,
    input  logic [3:0]             dq_in_i,
    output pfs_pad_t               pad_o,
    output logic                   dma_req_o,
    input  logic                   dma_ack_i
);

    if (PHASES != 8) begin : g_bad_phases
        $error("pfs_sequencer serves exactly eight phases");
    end

    function automatic logic [2:0] word_idx(input logic [`PFS_ADDR_W-1:0] a,
                                            input logic [`PFS_ADDR_W-1:0] base);
        logic [`PFS_ADDR_W-1:0] diff;
        diff = a - base;
        return diff[4:2];
    endfunction : word_idx

    // Byte 0 sits high unless little-end order is chosen
    function automatic logic [4:0] byte_lsb(input logic [1:0] idx, input logic le);
        return le ? {idx, 3'b000} : {~idx, 3'b000};
    endfunction : byte_lsb

    logic [1:0]             cfg_lane_q  [8];
    logic [11:0]            cfg_bcnt_q  [8];
    logic [1:0]             cfg_op_q    [8];
    logic [7:0]             ph_fault_q;
    logic [7:0]             ph_fin_q;
    logic [`PFS_DATA_W-1:0] pay_q       [8];
    logic                   go_q;
    logic                   done_q;
    logic                   err_q;
    logic [2:0]             cnt_q;
    logic                   order_q;
    logic                   dma_en_q;
    pfs_state_t             state_q;
    logic [2:0]             phase_q;
    logic [11:0]            left_q;
    logic [1:0]             idx_q;
    logic [2:0]             step_q;
    logic [7:0]             sh_q;
    logic [7:0]             rx_q;
    logic [7:0]             tries_q;
    logic                   fault_any_q;
    logic                   flush_q;
    logic                   sclk_q;
    logic                   cs_n_q;
    logic [`PFS_DATA_W-1:0] rdata_q;
    logic                   lk_s1_q;
    logic                   lk_s2_q;
    logic                   lk_s3_q;
    logic [3:0]             dq_s1_q;
    logic [3:0]             dq_s2_q;

    // Bus decode
    wire sel_ctrl = bus_i.addr == `PFS_OFF_CTRL;
    wire sel_cfg  = bus_i.addr >= `PFS_OFF_CFG0 && bus_i.addr <= `PFS_OFF_CFG7
                    && bus_i.addr[1:0] == 2'h0;
    wire sel_pay  = bus_i.addr >= `PFS_OFF_PAY0 && bus_i.addr <= `PFS_OFF_PAY7
                    && bus_i.addr[1:0] == 2'h0;
    wire [2:0] cfg_idx = word_idx(bus_i.addr, `PFS_OFF_CFG0);
    wire [2:0] pay_idx = word_idx(bus_i.addr, `PFS_OFF_PAY0);
    wire wr_ctrl  = bus_i.wr && sel_ctrl;
    wire wr_cfg   = bus_i.wr && sel_cfg;
    wire wr_pay   = bus_i.wr && sel_pay;
    wire busy     = state_q != S_IDLE;
    wire go_start = wr_ctrl && bus_i.wdata[`PFS_CTRL_GO] && !busy && !go_q;
    wire soft_rst = wr_ctrl && bus_i.wdata[`PFS_CTRL_SRST];

    // Current phase view
    wire [1:0]  cur_lane_raw = cfg_lane_q[phase_q];
    pfs_lane_t  cur_lane;
    // The prohibited width falls back to single lane rather than hanging
    assign cur_lane = (cur_lane_raw == PFS_LANE_BAD) ? PFS_LANE_SINGLE
                                                     : pfs_lane_t'(cur_lane_raw);
    pfs_op_t    cur_op;
    assign cur_op = pfs_op_t'(cfg_op_q[phase_q]);
    wire [11:0] cur_bcnt = cfg_bcnt_q[phase_q];
    wire [31:0] cur_pay  = pay_q[phase_q];
    wire [7:0]  lim      = cur_pay[`PFS_PAY_LIM_LO+:8];
    wire [7:0]  pmask    = cur_pay[`PFS_PAY_MASK_LO+:8];
    wire [7:0]  pexp     = cur_pay[`PFS_PAY_EXP_LO+:8];
    wire [4:0]  cur_lsb  = byte_lsb(idx_q, order_q);
    wire [7:0]  pay_byte = cur_pay[cur_lsb+:8];
    wire [7:0]  tx_byte  = (cur_op == PFS_OP_FILL) ? `PFS_FILL_BYTE : pay_byte;

    wire [2:0] last_step = (cur_lane == PFS_LANE_QUAD) ? `PFS_STEPS_QUAD :
                           (cur_lane == PFS_LANE_DUAL) ? `PFS_STEPS_DUAL :
                                                         `PFS_STEPS_SINGLE;
    wire [7:0] sh_next = (cur_lane == PFS_LANE_QUAD) ? {sh_q[3:0], 4'h0} :
                         (cur_lane == PFS_LANE_DUAL) ? {sh_q[5:0], 2'h0} :
                                                       {sh_q[6:0], 1'b0};
    wire [7:0] rx_next = (cur_lane == PFS_LANE_QUAD) ? {rx_q[3:0], dq_s2_q[3:0]} :
                         (cur_lane == PFS_LANE_DUAL) ? {rx_q[5:0], dq_s2_q[1:0]} :
                                                       {rx_q[6:0], dq_s2_q[1]};

    wire link_rise = lk_s2_q && !lk_s3_q;
    wire link_fall = !lk_s2_q && lk_s3_q;

    wire is_cmp     = cur_op == PFS_OP_CMP;
    wire is_rx      = cur_op == PFS_OP_RX;
    wire cmp_match  = (rx_q & pmask) == pexp;
    wire [7:0] tries_inc = tries_q + 8'h01;
    wire cmp_out    = lim != `PFS_LIM_INF && tries_inc == lim;
    wire last_byte  = left_q == 12'h001;
    wire group_end  = idx_q == `PFS_LAST_IDX;
    wire dma_phase  = dma_en_q && (cur_op == PFS_OP_TX || is_rx);
    wire last_phase = phase_q == cnt_q;
    wire byte_evt   = state_q == S_BYTE;

    // Link clock and data pins are foreign; two stages before use
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lk_s1_q <= 1'b0;
            lk_s2_q <= 1'b0;
            lk_s3_q <= 1'b0;
            dq_s1_q <= 4'h0;
            dq_s2_q <= 4'h0;
        end else if (ce_i) begin
            lk_s1_q <= link_clk_i;
            lk_s2_q <= lk_s1_q;
            lk_s3_q <= lk_s2_q;
            dq_s1_q <= dq_in_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // Control register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            go_q     <= 1'b0;
            done_q   <= 1'b0;
            err_q    <= 1'b0;
            cnt_q    <= `PFS_CNT_RST;
            order_q  <= 1'b0;
            dma_en_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                cnt_q    <= bus_i.wdata[`PFS_CTRL_CNT_HI:`PFS_CTRL_CNT_LO];
                order_q  <= bus_i.wdata[`PFS_CTRL_ORDER];
                dma_en_q <= bus_i.wdata[`PFS_CTRL_DMA];
                if (!bus_i.wdata[`PFS_CTRL_DONE]) done_q <= 1'b0;
                if (!bus_i.wdata[`PFS_CTRL_ERR])  err_q  <= 1'b0;
            end
            if (go_start) begin
                go_q   <= 1'b1;
                done_q <= 1'b0;
                err_q  <= 1'b0;
            end
            if (soft_rst || (state_q == S_NEXT && last_phase)) begin
                go_q <= 1'b0;
            end
            // Hardware set placed last so it wins over a clear
            if (state_q == S_NEXT && last_phase && !flush_q) begin
                done_q <= 1'b1;
                err_q  <= fault_any_q;
            end
            if (state_q == S_FLUSH && dma_ack_i) begin
                done_q <= 1'b1;
                err_q  <= fault_any_q;
            end
        end
    end

    // Phase configuration and payload storage
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 8; i++) begin
                cfg_lane_q[i] <= `PFS_LANE_RST;
                cfg_bcnt_q[i] <= `PFS_BCNT_RST;
                cfg_op_q[i]   <= `PFS_OP_RST;
                pay_q[i]      <= `PFS_PAY_RST;
            end
            ph_fault_q <= 8'h00;
            ph_fin_q   <= 8'h00;
        end else if (ce_i) begin
            if (wr_cfg) begin
                cfg_lane_q[cfg_idx] <= bus_i.wdata[`PFS_CFG_LANE_HI:`PFS_CFG_LANE_LO];
                cfg_bcnt_q[cfg_idx] <= bus_i.wdata[`PFS_CFG_BCNT_HI:`PFS_CFG_BCNT_LO];
                cfg_op_q[cfg_idx]   <= bus_i.wdata[`PFS_CFG_OP_HI:`PFS_CFG_OP_LO];
            end
            if (wr_pay) pay_q[pay_idx] <= bus_i.wdata;
            if (go_start) begin
                ph_fault_q <= 8'h00;
                ph_fin_q   <= 8'h00;
            end
            if (byte_evt && is_rx) pay_q[phase_q][cur_lsb+:8] <= rx_q;
            if (byte_evt && is_cmp) pay_q[phase_q][`PFS_PAY_READ_LO+:8] <= rx_q;
            if (byte_evt && is_cmp && !cmp_match && cmp_out) begin
                ph_fault_q[phase_q] <= 1'b1;
            end
            if (state_q == S_NEXT) ph_fin_q[phase_q] <= 1'b1;
        end
    end

    // Sequencer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q     <= S_IDLE;
            phase_q     <= 3'h0;
            left_q      <= 12'h000;
            idx_q       <= 2'h0;
            step_q      <= 3'h0;
            sh_q        <= 8'h00;
            rx_q        <= 8'h00;
            tries_q     <= 8'h00;
            fault_any_q <= 1'b0;
            flush_q     <= 1'b0;
            sclk_q      <= 1'b0;
            cs_n_q      <= 1'b1;
        end else if (ce_i) begin
            if (soft_rst) begin
                // The only way out of an unbounded compare loop
                state_q <= S_IDLE;
                sclk_q  <= 1'b0;
                cs_n_q  <= 1'b1;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (go_start) begin
                            phase_q     <= 3'h0;
                            fault_any_q <= 1'b0;
                            flush_q     <= 1'b0;
                            cs_n_q      <= 1'b0;
                            state_q     <= S_LOAD;
                        end
                    end
                    S_LOAD: begin
                        left_q  <= cur_bcnt;
                        idx_q   <= 2'h0;
                        tries_q <= 8'h00;
                        // Byte count means nothing to a compare loop
                        state_q <= (!is_cmp && cur_bcnt == 12'h000) ? S_NEXT : S_FETCH;
                    end
                    S_FETCH: begin
                        sh_q    <= is_cmp ? `PFS_FILL_BYTE : tx_byte;
                        step_q  <= 3'h0;
                        state_q <= S_SHIFT;
                    end
                    S_SHIFT: begin
                        if (link_rise && !sclk_q) begin
                            sclk_q <= 1'b1;
                            rx_q   <= rx_next;
                        end else if (link_fall && sclk_q) begin
                            sclk_q <= 1'b0;
                            if (step_q == last_step) begin
                                state_q <= S_BYTE;
                            end else begin
                                step_q <= step_q + 3'h1;
                                sh_q   <= sh_next;
                            end
                        end
                    end
                    S_BYTE: begin
                        if (is_cmp) begin
                            tries_q <= tries_inc;
                            if (cmp_match) begin
                                state_q <= S_NEXT;
                            end else if (cmp_out) begin
                                fault_any_q <= 1'b1;
                                state_q     <= S_NEXT;
                            end else begin
                                state_q <= S_FETCH;
                            end
                        end else begin
                            left_q <= left_q - 12'h001;
                            idx_q  <= idx_q + 2'h1;
                            if (last_byte) begin
                                flush_q <= dma_phase && is_rx;
                                state_q <= S_NEXT;
                            end else if (dma_phase && group_end) begin
                                state_q <= S_DMA;
                            end else begin
                                state_q <= S_FETCH;
                            end
                        end
                    end
                    S_DMA: begin
                        if (dma_ack_i) state_q <= S_FETCH;
                    end
                    S_NEXT: begin
                        if (last_phase) begin
                            cs_n_q  <= 1'b1;
                            state_q <= flush_q ? S_FLUSH : S_IDLE;
                        end else begin
                            phase_q <= phase_q + 3'h1;
                            state_q <= S_LOAD;
                        end
                    end
                    S_FLUSH: begin
                        if (dma_ack_i) state_q <= S_IDLE;
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // Read data, one cycle after the strobe
    wire running = state_q != S_IDLE && state_q != S_FLUSH;
    wire [7:0] act_vec = running ? (8'h01 << phase_q) : 8'h00;
    wire [31:0] ctrl_rd = {23'h0, dma_en_q, order_q, cnt_q, 1'b0,
                           err_q, done_q, go_q};
    wire [31:0] cfg_rd  = {10'h000, cfg_lane_q[cfg_idx], cfg_bcnt_q[cfg_idx], 2'h0,
                           cfg_op_q[cfg_idx], 1'b0, ph_fault_q[cfg_idx],
                           ph_fin_q[cfg_idx], act_vec[cfg_idx]};
    wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd :
                          sel_cfg  ? cfg_rd  :
                          sel_pay  ? pay_q[pay_idx] : 32'h0000_0000;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) rdata_q <= 32'h0000_0000;
        else if (ce_i && bus_i.rd) rdata_q <= rd_mux;
    end

    assign rdata_o = rdata_q;

    // Pads: lanes driven only for outgoing phases; single lane drives line 0 in every running phase
    wire tx_phase = running && (cur_op == PFS_OP_TX || cur_op == PFS_OP_FILL);
    wire [3:0] lane_bits = (cur_lane == PFS_LANE_QUAD) ? 4'hf :
                           (cur_lane == PFS_LANE_DUAL) ? 4'h3 : 4'h1;
    wire [3:0] dq_val = (cur_lane == PFS_LANE_QUAD) ? sh_q[7:4] :
                        (cur_lane == PFS_LANE_DUAL) ? {2'h0, sh_q[7:6]} :
                                                      {3'h0, sh_q[7]};
    assign pad_o.sclk   = sclk_q;
    assign pad_o.cs_n   = cs_n_q;
    assign pad_o.dq_out = running ? dq_val : 4'h0;
    assign pad_o.dq_oe  = tx_phase ? lane_bits :
                          (running && cur_lane == PFS_LANE_SINGLE) ? 4'h1 : 4'h0;
    assign dma_req_o    = state_q == S_DMA || state_q == S_FLUSH;

    cs_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        running |-> !cs_n_q) else $error("chip select dropped mid communication");

    done_after_dma_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && state_q == S_FLUSH && !dma_ack_i && !wr_ctrl |=> !done_q)
        else $error("complete flag set before DMA drain");

    go_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && state_q == S_NEXT && last_phase |=> !go_q && cs_n_q)
        else $error("go bit not cleared at serial end");

    err_cause_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(err_q) |-> $past(fault_any_q) && done_q)
        else $error("error flag without a phase fault");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && go_start |=> !done_q && !err_q && ph_fin_q == 8'h00)
        else $error("flags survived a go start");

    fault_limit_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && byte_evt && is_cmp && !cmp_match && cmp_out && !soft_rst
        |=> ph_fault_q[$past(phase_q)] && state_q == S_NEXT)
        else $error("compare limit did not raise phase fault");

    fill_byte_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && state_q == S_FETCH && cur_op == PFS_OP_FILL && !soft_rst
        |=> sh_q == `PFS_FILL_BYTE) else $error("filler byte not all ones");

    phase_order_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && state_q == S_NEXT && !last_phase && !soft_rst
        |=> phase_q == $past(phase_q) + 3'h1 ##1 act_vec[phase_q])
        else $error("phases not run in index order");

    rx_store_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && byte_evt && is_rx && !wr_pay
        |=> pay_q[$past(phase_q)][$past(cur_lsb)+:8] == $past(rx_q))
        else $error("received byte not stored in order");

endmodule : pfs_sequencer

// [hw/pfs_defines.svh]
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

`define PFS_PHASES       8
`define PFS_DATA_W       32
`define PFS_ADDR_W       8

`define PFS_OFF_CTRL     8'h00
`define PFS_OFF_CFG0     8'h10
`define PFS_OFF_CFG7     8'h2c
`define PFS_OFF_PAY0     8'h30
`define PFS_OFF_PAY7     8'h4c

`define PFS_CTRL_GO      0
`define PFS_CTRL_DONE    1
`define PFS_CTRL_ERR     2
`define PFS_CTRL_CNT_LO  4
`define PFS_CTRL_CNT_HI  6
`define PFS_CTRL_ORDER   7
`define PFS_CTRL_DMA     8
`define PFS_CTRL_SRST    9

`define PFS_CFG_LANE_LO  20
`define PFS_CFG_LANE_HI  21
`define PFS_CFG_BCNT_LO  8
`define PFS_CFG_BCNT_HI  19
`define PFS_CFG_OP_LO    4
`define PFS_CFG_OP_HI    5
`define PFS_CFG_FAULT    2
`define PFS_CFG_FIN      1
`define PFS_CFG_ACT      0

`define PFS_PAY_LIM_LO   24
`define PFS_PAY_MASK_LO  16
`define PFS_PAY_EXP_LO   8
`define PFS_PAY_READ_LO  0

`define PFS_CNT_RST      3'h0
`define PFS_BCNT_RST     12'h000
`define PFS_LANE_RST     2'h0
`define PFS_OP_RST       2'h0
`define PFS_PAY_RST      32'h0000_0000
`define PFS_FILL_BYTE    8'hff
`define PFS_LIM_INF      8'h00
`define PFS_LAST_IDX     2'h3
`define PFS_STEPS_SINGLE 3'h7
`define PFS_STEPS_DUAL   3'h3
`define PFS_STEPS_QUAD   3'h1

`endif

// [hw/pfs_pkg.sv]
`include "pfs_defines.svh"

package pfs_pkg;

    typedef enum logic [1:0] {
        PFS_LANE_SINGLE = 2'h0,
        PFS_LANE_DUAL   = 2'h1,
        PFS_LANE_QUAD   = 2'h2,
        PFS_LANE_BAD    = 2'h3
    } pfs_lane_t;

    typedef enum logic [1:0] {
        PFS_OP_TX   = 2'h0,
        PFS_OP_FILL = 2'h1,
        PFS_OP_RX   = 2'h2,
        PFS_OP_CMP  = 2'h3
    } pfs_op_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_LOAD,
        S_FETCH,
        S_SHIFT,
        S_BYTE,
        S_DMA,
        S_NEXT,
        S_FLUSH
    } pfs_state_t;

    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`PFS_ADDR_W-1:0]   addr;
        logic [`PFS_DATA_W-1:0]   wdata;
    } pfs_bus_t;

    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] dq_out;
        logic [3:0] dq_oe;
    } pfs_pad_t;

endpackage : pfs_pkg

// [dv/pfs_flash_model.sv]
`timescale 1ns/100ps
module pfs_flash_model
    import pfs_pkg::*;
(
    input  pfs_pad_t   pad_i,
    input  logic [7:0] status_i,
    output logic [3:0] dq_o,
    output logic [7:0] cmd_o,
    output logic [7:0] nib_o
);
    logic [2:0] bit_q  = 3'h0;
    logic [3:0] last_q = 4'h0;
    // Mode 0: host samples on the rise, so the answer moves on each fall
    always @(negedge pad_i.cs_n) bit_q = 3'h0;
    always @(negedge pad_i.sclk) bit_q = bit_q + 3'h1;
    always @(posedge pad_i.sclk) cmd_o = {cmd_o[6:0], pad_i.dq_out[0]};
    // All four lines, so wide lanes can be seen nibble by nibble
    always @(posedge pad_i.sclk) nib_o = {nib_o[3:0], pad_i.dq_out};
    // Deselected lines show the inverse of the last level, never a stale match
    always @(posedge pad_i.cs_n) last_q = ~{2'h0, status_i[3'h7 - bit_q], 1'h0};
    assign dq_o = pad_i.cs_n ? last_q : {2'h0, status_i[3'h7 - bit_q], 1'h0};
endmodule : pfs_flash_model

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import pfs_pkg::*;
;
    logic        clk_i    = 1'b0;
    logic        reset_i  = 1'b1;
    logic        link_clk = 1'b0;
    pfs_bus_t    bus      = '0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic [3:0]  dq;
    logic [7:0]  cmd;
    logic [7:0]  nib;
    logic        dma_req;
    logic        dma_ack  = 1'b0;
    logic [7:0]  status   = 8'h5a;
    pfs_pad_t    pad;
    int          err_count  = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    int          dma_n      = 0;
    always #50 clk_i = ~clk_i;
    always #400 link_clk = ~link_clk;
    // DMA side: one-cycle done pulse the cycle after a request is seen
    always @(posedge clk_i) begin
        dma_ack <= dma_req && !dma_ack;
        if (dma_req && !dma_ack) dma_n++;
    end
    pfs_sequencer dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .bus_i(bus),
        .rdata_o(rdata), .link_clk_i(link_clk), .dq_in_i(dq), .pad_o(pad),
        .dma_req_o(dma_req), .dma_ack_i(dma_ack));
    pfs_flash_model flash (.pad_i(pad), .status_i(status), .dq_o(dq), .cmd_o(cmd),
        .nib_o(nib));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge clk_i);
        bus.wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge clk_i);
        bus.rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, got);
        chk(got, e);
    endtask : rchk
    // Start, then poll control until hardware drops go
    task automatic run(input logic [31:0] ctl);
        wr(8'h00, ctl);
        repeat (400) begin
            rd(8'h00, got);
            if (got[0] === 1'b0) break;
        end
    endtask : run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rchk(8'h00, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h04, 32'h0);
        wr(8'h2c, 32'hffff_ffff);
        rchk(8'h2c, 32'h003f_ff30);
        $display("test registers done");
        wr(8'h10, 32'h0000_0100);
        wr(8'h30, 32'ha500_0000);
        run(32'h0000_0001);
        chk(got, 32'h0000_0002);
        chk({24'h0, cmd}, 32'h0000_00a5);
        rchk(8'h10, 32'h0000_0102);
        wr(8'h30, 32'h0000_003c);
        run(32'h0000_0081);
        chk(got, 32'h0000_0082);
        chk({24'h0, cmd}, 32'h0000_003c);
        $display("test transmit done");
        wr(8'h30, 32'h0500_0000);
        wr(8'h14, 32'h0000_0030);
        wr(8'h34, 32'h030f_0b00);
        run(32'h0000_0011);
        chk(got, 32'h0000_0016);
        rchk(8'h14, 32'h0000_0036);
        rchk(8'h34, 32'h030f_0b5a);
        wr(8'h34, 32'h030f_0a00);
        run(32'h0000_0011);
        chk(got, 32'h0000_0012);
        rchk(8'h14, 32'h0000_0032);
        wr(8'h00, 32'h0);
        rchk(8'h00, 32'h0);
        $display("test compare done");
        wr(8'h14, 32'h0000_0520);
        run(32'h0000_0111);
        rchk(8'h00, 32'h0000_0112);
        chk(dma_n, 32'h0000_0002);
        rchk(8'h34, 32'h5a5a_5a5a);
        $display("test dma done");
        wr(8'h10, 32'h0020_0100);
        wr(8'h30, 32'ha500_0000);
        run(32'h0000_0001);
        chk({24'h0, nib}, 32'h0000_00a5);
        wr(8'h10, 32'h0010_0110);
        run(32'h0000_0001);
        chk({24'h0, nib}, 32'h0000_0033);
        $display("test lanes done");
        finish_test();
    end
endmodule : tb_top
